//--- rtl/srtc_defines.svh
// Purpose: constants for the sync rotation and transmit mute controller
// Assumes: 8-bit register data, 12-bit register address
// Notes: included by bare name from the package and the top module
//
// Functional notes
// R1: software keeps the sync required setting bit at 1 in subclass 0 and 1.
// R2: with osc reset after rotation set, reset all oscillators on reset or rotation.
// R3: a separate oscillator sync start write also resets all oscillators.
// R4: rotation action field zero means rotation touches neither link clocks nor datapath.
// R5: action bit 0 set drops the links and resets link clocks on rotation.
// R6: software should set action bit 0 so link clocks realign after rotation.
// R7: action bit 1 set soft ramps the datapath off and on around rotation.
// R8: software sets action bit 1 only with the amplifier protection block in use.
// R9: action field 11 applies both link clock reset and datapath soft ramp.
// R10: dac1 mute select at 1 zeroes dac1 at once while its pin is low.
// R11: dac1 mute select at 0 keeps dac1 output normal whatever the pin.
// R12: dac0 mute select at bit 4 zeroes dac0 the same way under its pin.
// R13: pins pass a synchronizer; rotation actions are taken in the event cycle; here the action outputs follow one cycle after the event.
`ifndef SRTC_DEFINES_SVH
`define SRTC_DEFINES_SVH

// ==========================================================
// register offsets
`define SRTC_ADDR_ROT 12'h03b
`define SRTC_ADDR_TXMUTE 12'h03f
`define SRTC_ADDR_STATUS 12'h040
`define SRTC_ADDR_OSCSYNC 12'h1e7

// ==========================================================
// reset values and write masks
`define SRTC_ROT_RESET 8'hb0
`define SRTC_ROT_WMASK 8'hf3
`define SRTC_TXMUTE_RESET 8'h00

// ==========================================================
// field positions
`define SRTC_ROT_SYNCLOGIC 7
`define SRTC_ROT_SYNCREQ 5
`define SRTC_ROT_OSCRST 4
`define SRTC_ROT_ACT_LINK 0
`define SRTC_ROT_ACT_RAMP 1
`define SRTC_TX_DAC1 5
`define SRTC_TX_DAC0 4
`define SRTC_OSCSYNC_GO 0
`define SRTC_ST_PIN0 0
`define SRTC_ST_PIN1 1
`define SRTC_ST_MUTE0 2
`define SRTC_ST_MUTE1 3
`define SRTC_ST_RAMP 4

// ==========================================================
// soft ramp timing
`define SRTC_RAMP_DIV 4'h3
`define SRTC_RAMP_STEP 9'h010
`define SRTC_GAIN_UNITY 9'h100
`define SRTC_HOLD_STEPS 4'h8

`endif

//--- rtl/srtc_pkg.sv
// Purpose: shared types of the sync rotation and transmit mute controller
// Assumes: constants come from srtc_defines.svh
// Notes: one-hot ramp states, bus and sample carriers
`include "srtc_defines.svh"

package srtc_pkg;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srtc_bus_req_t;

  // ==========================================================
  // one complex datapath sample
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } srtc_sample_t;

  // ==========================================================
  // soft ramp sequencer states
  typedef enum logic [3:0] {
    SRTC_RAMP_IDLE = 4'b0001,
    SRTC_RAMP_DOWN = 4'b0010,
    SRTC_RAMP_HOLD = 4'b0100,
    SRTC_RAMP_UP = 4'b1000
  } srtc_ramp_state_t;

endpackage

//--- rtl/srtc_pin_sync.sv
// Purpose: bring the two transmit enable pins into the clk domain
// Assumes: pins are asynchronous to clk
// Notes: a level counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module srtc_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins
  input wire logic [1:0] pin_raw,
  // filtered levels
  output logic [1:0] pin_lvl
);

  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;

  // ==========================================================
  // three stage chain; stage one feeds only stage two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================================
  // accept a level only when the last two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_lvl <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (s2_r[k] == s3_r[k]) begin
          pin_lvl[k] <= s3_r[k];
        end
      end
    end
  end

endmodule // srtc_pin_sync

`default_nettype wire

//--- rtl/srtc_top.sv
// Purpose: rotation action and transmit pin mute control of two dac datapaths
// Assumes: rotation and digital reset events are one-cycle pulses on clk
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "srtc_defines.svh"

module srtc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire srtc_pkg::srtc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // synchronization events
  input wire logic rotation_evt,
  input wire logic digital_reset_evt,
  // transmit enable pins
  input wire logic dac0_transmit_pin,
  input wire logic dac1_transmit_pin,
  // datapath samples
  input wire srtc_pkg::srtc_sample_t dac0_in,
  input wire srtc_pkg::srtc_sample_t dac1_in,
  output srtc_pkg::srtc_sample_t dac0_out,
  output srtc_pkg::srtc_sample_t dac1_out,
  // action pulses
  output logic osc_reset,
  output logic link_realign,
  // status and configuration levels
  output logic ramp_active,
  output logic dac0_muted,
  output logic dac1_muted,
  output logic sync_logic_en,
  output logic sync_required_setting
);

  import srtc_pkg::*;

  // ==========================================================
  // helper functions

  // scale one component by a gain where unity is 0x100
  function automatic logic signed [15:0] srtc_scale(
    input logic signed [15:0] s,
    input logic [8:0] g
  );
    logic signed [25:0] p;
    p = s * $signed({1'b0, g});
    return p[23:8];
  endfunction

  // scale a whole complex sample
  function automatic srtc_sample_t srtc_scale_smp(
    input srtc_sample_t s,
    input logic [8:0] g
  );
    srtc_sample_t r;
    r.i = srtc_scale(s.i, g);
    r.q = srtc_scale(s.q, g);
    return r;
  endfunction

  // ==========================================================
  // declarations
  logic [7:0] rot_cfg_r;
  logic [7:0] txmute_r;
  logic osc_sync_go;
  logic [1:0] pin_lvl;
  logic dac0_mute_nxt;
  logic dac1_mute_nxt;
  logic [3:0] div_cnt_r;
  logic step_en;
  srtc_ramp_state_t ramp_state_r;
  srtc_ramp_state_t ramp_state_nxt;
  logic [8:0] gain_r;
  logic [8:0] gain_nxt;
  logic [3:0] hold_cnt_r;
  logic [3:0] hold_cnt_nxt;
  logic act_link;
  logic act_ramp;
  logic osc_rst_en;
  logic [7:0] status;
  logic wr_rot;
  logic wr_txmute;

  // ==========================================================
  // register decode

  // write strobes per register
  always_comb begin
    wr_rot = 1'b0;
    wr_txmute = 1'b0;
    osc_sync_go = 1'b0;
    if (bus_req.wr && bus_req.addr == `SRTC_ADDR_ROT) begin
      wr_rot = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `SRTC_ADDR_TXMUTE) begin
      wr_txmute = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `SRTC_ADDR_OSCSYNC) begin
      osc_sync_go = bus_req.wdata[`SRTC_OSCSYNC_GO]; // R3
    end
  end

  // rotation control register; bits 3:2 stay zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rot_cfg_r <= `SRTC_ROT_RESET;
    end else if (wr_rot) begin
      rot_cfg_r <= bus_req.wdata & `SRTC_ROT_WMASK;
    end
  end

  // transmit mute select register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txmute_r <= `SRTC_TXMUTE_RESET;
    end else if (wr_txmute) begin
      txmute_r <= bus_req.wdata;
    end
  end

  // field views
  assign act_link = rot_cfg_r[`SRTC_ROT_ACT_LINK];
  assign act_ramp = rot_cfg_r[`SRTC_ROT_ACT_RAMP];
  assign osc_rst_en = rot_cfg_r[`SRTC_ROT_OSCRST];

  // ==========================================================
  // status and read path

  // live state of the block
  always_comb begin
    status = 8'h00;
    status[`SRTC_ST_PIN0] = pin_lvl[0];
    status[`SRTC_ST_PIN1] = pin_lvl[1];
    status[`SRTC_ST_MUTE0] = dac0_muted;
    status[`SRTC_ST_MUTE1] = dac1_muted;
    status[`SRTC_ST_RAMP] = ramp_active;
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (!bus_req.rd) begin
      rd_data <= 8'h00;
    end else if (bus_req.addr == `SRTC_ADDR_ROT) begin
      rd_data <= rot_cfg_r;
    end else if (bus_req.addr == `SRTC_ADDR_TXMUTE) begin
      rd_data <= txmute_r;
    end else if (bus_req.addr == `SRTC_ADDR_STATUS) begin
      rd_data <= status;
    end else begin
      rd_data <= 8'h00; // unmapped and write-only read as zero
    end
  end

  // configuration levels straight from the register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_logic_en <= 1'b1;
      sync_required_setting <= 1'b1;
    end else begin
      sync_logic_en <= rot_cfg_r[`SRTC_ROT_SYNCLOGIC];
      sync_required_setting <= rot_cfg_r[`SRTC_ROT_SYNCREQ]; // R1
    end
  end

  // ==========================================================
  // rotation action pulses

  // oscillator reset on rotation, digital reset or sync start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_reset <= 1'b0;
    end else begin
      osc_reset <= (osc_rst_en && (rotation_evt || digital_reset_evt)) // R2 R13
                   || osc_sync_go; // R3
    end
  end

  // link drop and link clock realign only when action bit 0 is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_realign <= 1'b0;
    end else begin
      link_realign <= rotation_evt && act_link; // R4 R5 R9 R13
    end
  end

  // ==========================================================
  // soft ramp sequencer

  // step enable divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 4'h0;
    end else if (div_cnt_r == `SRTC_RAMP_DIV) begin
      div_cnt_r <= 4'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  assign step_en = (div_cnt_r == `SRTC_RAMP_DIV);

  // ramp down, hold while the rotation settles, ramp up
  always_comb begin
    ramp_state_nxt = ramp_state_r;
    gain_nxt = gain_r;
    hold_cnt_nxt = hold_cnt_r;
    if (rotation_evt && act_ramp) begin
      ramp_state_nxt = SRTC_RAMP_DOWN; // R7 R9 R13
    end else begin
      case (ramp_state_r)
        SRTC_RAMP_IDLE: begin
          gain_nxt = `SRTC_GAIN_UNITY;
        end
        SRTC_RAMP_DOWN: begin
          if (step_en) begin
            if (gain_r <= `SRTC_RAMP_STEP) begin
              gain_nxt = 9'h000;
              hold_cnt_nxt = 4'h0;
              ramp_state_nxt = SRTC_RAMP_HOLD;
            end else begin
              gain_nxt = gain_r - `SRTC_RAMP_STEP;
            end
          end
        end
        SRTC_RAMP_HOLD: begin
          if (step_en) begin
            if (hold_cnt_r == `SRTC_HOLD_STEPS - 4'h1) begin
              ramp_state_nxt = SRTC_RAMP_UP;
            end else begin
              hold_cnt_nxt = hold_cnt_r + 4'h1;
            end
          end
        end
        SRTC_RAMP_UP: begin
          if (step_en) begin
            if (gain_r >= `SRTC_GAIN_UNITY - `SRTC_RAMP_STEP) begin
              gain_nxt = `SRTC_GAIN_UNITY;
              ramp_state_nxt = SRTC_RAMP_IDLE;
            end else begin
              gain_nxt = gain_r + `SRTC_RAMP_STEP;
            end
          end
        end
        default: begin
          ramp_state_nxt = SRTC_RAMP_IDLE;
          gain_nxt = `SRTC_GAIN_UNITY;
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_state_r <= SRTC_RAMP_IDLE;
      gain_r <= `SRTC_GAIN_UNITY;
      hold_cnt_r <= 4'h0;
    end else begin
      ramp_state_r <= ramp_state_nxt;
      gain_r <= gain_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // busy flag seen from outside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_active <= 1'b0;
    end else begin
      ramp_active <= (ramp_state_nxt != SRTC_RAMP_IDLE);
    end
  end

  // ==========================================================
  // transmit pin mute

  // pins enter the clk domain through three stages
  srtc_pin_sync u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_raw({dac1_transmit_pin, dac0_transmit_pin}), // R13
    .pin_lvl(pin_lvl)
  );

  // mute only when selected and the pin is low
  assign dac0_mute_nxt = txmute_r[`SRTC_TX_DAC0] && !pin_lvl[0]; // R12
  assign dac1_mute_nxt = txmute_r[`SRTC_TX_DAC1] && !pin_lvl[1]; // R10 R11

  // mute flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac0_muted <= 1'b0;
      dac1_muted <= 1'b0;
    end else begin
      dac0_muted <= dac0_mute_nxt;
      dac1_muted <= dac1_mute_nxt;
    end
  end

  // ==========================================================
  // datapath output

  // dac0: zero at once when muted, else scaled by the ramp gain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac0_out <= '0;
    end else if (dac0_mute_nxt) begin
      dac0_out <= '0; // R12
    end else begin
      dac0_out <= srtc_scale_smp(dac0_in, gain_r); // R7
    end
  end

  // dac1: same treatment under its own pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac1_out <= '0;
    end else if (dac1_mute_nxt) begin
      dac1_out <= '0; // R10
    end else begin
      dac1_out <= srtc_scale_smp(dac1_in, gain_r); // R11
    end
  end

endmodule // srtc_top

`default_nettype wire

//--- testbench/srtc_top_monitor.sv
// Purpose: port checker for srtc_top
// Assumes: control register writes land on the strobe edge
// Notes: shadows the rotation and mute select registers from the bus
`timescale 1ns/1ns
`default_nettype none
`include "srtc_defines.svh"

module srtc_top_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire srtc_pkg::srtc_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  // events and pins
  input wire logic rotation_evt,
  input wire logic digital_reset_evt,
  input wire logic dac0_transmit_pin,
  input wire logic dac1_transmit_pin,
  // watched outputs
  input wire srtc_pkg::srtc_sample_t dac0_out,
  input wire srtc_pkg::srtc_sample_t dac1_out,
  input wire logic osc_reset,
  input wire logic link_realign,
  input wire logic ramp_active,
  input wire logic dac0_muted,
  input wire logic dac1_muted
);
  import srtc_pkg::*;
  logic [7:0] rot_r;
  logic [7:0] tx_r;

  // shadow copies of the two control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rot_r <= `SRTC_ROT_RESET;
      tx_r <= `SRTC_TXMUTE_RESET;
    end else if (bus_req.wr && bus_req.addr == `SRTC_ADDR_ROT) begin
      rot_r <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == `SRTC_ADDR_TXMUTE) begin
      tx_r <= bus_req.wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // rotation actions
  a_link_on_rot: assert property (rotation_evt && rot_r[0] |=> link_realign)
    else $error("link realign missing after rotation");
  a_link_quiet: assert property (!(rotation_evt && rot_r[0]) |=> !link_realign)
    else $error("link realign without cause");
  a_osc_on_event: assert property ((rotation_evt || digital_reset_evt) && rot_r[4]
    |=> osc_reset) else $error("oscillator reset missing after event");
  a_osc_sync_go: assert property (bus_req.wr && bus_req.addr == `SRTC_ADDR_OSCSYNC
    && bus_req.wdata[0] |=> osc_reset) else $error("sync start ignored");
  a_ramp_on_rot: assert property (rotation_evt && rot_r[1] |=> ramp_active)
    else $error("soft ramp did not start");
  a_ramp_quiet: assert property (!ramp_active && !(rotation_evt && rot_r[1])
    |=> !ramp_active) else $error("soft ramp without rotation");

  // ==========================================================
  // transmit pin mute
  a_dac1_mutes: assert property ((tx_r[5] && !dac1_transmit_pin) [*6]
    |=> dac1_muted && dac1_out == '0) else $error("dac1 not zeroed");
  a_dac1_free: assert property (!tx_r[5] |=> !dac1_muted)
    else $error("dac1 muted with select clear");
  a_dac0_mutes: assert property ((tx_r[4] && !dac0_transmit_pin) [*6]
    |=> dac0_muted && dac0_out == '0) else $error("dac0 not zeroed");
  a_pin_synced: assert property ($fell(dac1_transmit_pin) && !dac1_muted
    |=> !dac1_muted) else $error("pin used before synchronizer");
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data outside read cycle");
endmodule // srtc_top_monitor

bind srtc_top srtc_top_monitor u_monitor (.clk(clk), .rst(rst), .bus_req(bus_req),
  .rd_data(rd_data), .rotation_evt(rotation_evt), .digital_reset_evt(digital_reset_evt),
  .dac0_transmit_pin(dac0_transmit_pin), .dac1_transmit_pin(dac1_transmit_pin),
  .dac0_out(dac0_out), .dac1_out(dac1_out), .osc_reset(osc_reset),
  .link_realign(link_realign), .ramp_active(ramp_active), .dac0_muted(dac0_muted),
  .dac1_muted(dac1_muted));
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for srtc_top
// Assumes: 25 MHz clock, one-cycle bus strobes
// Notes: rotation modes, sync start and pin mute checked at the ports
`timescale 1ns/1ns
`default_nettype none
`include "srtc_defines.svh"

module testbench;
  import srtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  srtc_bus_req_t req = '0;
  logic [7:0] rd_data;
  logic rot = 1'b0;
  logic drst = 1'b0;
  logic pin0 = 1'b1;
  logic pin1 = 1'b1;
  srtc_sample_t in0 = 32'h1234_5678;
  srtc_sample_t in1 = 32'h0abc_0def;
  srtc_sample_t out0;
  srtc_sample_t out1;
  logic osc, link, ramp, mut0, mut1, slen, sreq;
  int errors = 0;
  int compares = 0;

  // 40 ns clock
  always #20 clk = ~clk;

  srtc_top DUT (.clk(clk), .rst(rst), .bus_req(req), .rd_data(rd_data),
    .rotation_evt(rot), .digital_reset_evt(drst), .dac0_transmit_pin(pin0),
    .dac1_transmit_pin(pin1), .dac0_in(in0), .dac1_in(in1), .dac0_out(out0),
    .dac1_out(out1), .osc_reset(osc), .link_realign(link), .ramp_active(ramp),
    .dac0_muted(mut0), .dac1_muted(mut1), .sync_logic_en(slen),
    .sync_required_setting(sreq));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    check(rd_data, exp);
  endtask

  // one-cycle event pulse, then look in the following cycle
  task automatic fire(input logic r, input logic d);
    @(posedge clk);
    rot <= r;
    drst <= d;
    @(posedge clk);
    rot <= 1'b0;
    drst <= 1'b0;
    @(negedge clk);
  endtask

  task automatic give_verdict;
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({slen, sreq}, 2'b11);
    rd_reg(`SRTC_ADDR_ROT, `SRTC_ROT_RESET);
    rd_reg(`SRTC_ADDR_TXMUTE, 8'h00);
    rd_reg(`SRTC_ADDR_STATUS, 8'h03);
    wr_reg(`SRTC_ADDR_ROT, 8'hff);
    rd_reg(`SRTC_ADDR_ROT, 8'hf3);
    wr_reg(12'h123, 8'h5a);
    rd_reg(12'h123, 8'h00);
    rd_reg(`SRTC_ADDR_OSCSYNC, 8'h00);
    $display("test registers done");
    // every rotation action code, oscillator reset enabled
    for (int m = 0; m < 4; m++) begin
      wr_reg(`SRTC_ADDR_ROT, 8'hb0 | m[7:0]);
      fire(1'b1, 1'b0);
      check(link, m[0]);
      check(osc, 1'b1);
      check(ramp, m[1]);
      if (m[1]) begin
        repeat (80) @(negedge clk);
        check(out0, 32'h0);
        for (int i = 0; i < 400 && ramp; i++) @(negedge clk);
        check(ramp, 1'b0);
        // samples still carry the last step for one more clock
        @(negedge clk);
      end
      check(out0, in0);
    end
    $display("test rotation modes done");
    wr_reg(`SRTC_ADDR_ROT, 8'ha1);
    fire(1'b1, 1'b0);
    check({osc, link}, 2'b01);
    wr_reg(`SRTC_ADDR_ROT, 8'hb1);
    fire(1'b0, 1'b1);
    check({osc, link}, 2'b10);
    wr_reg(`SRTC_ADDR_OSCSYNC, 8'h01);
    @(negedge clk);
    check(osc, 1'b1);
    @(negedge clk);
    check(osc, 1'b0);
    $display("test oscillator reset done");
    // pin mute on both datapaths
    wr_reg(`SRTC_ADDR_TXMUTE, 8'h30);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    repeat (2) @(negedge clk);
    check({mut0, mut1}, 2'b00);
    repeat (8) @(negedge clk);
    check({mut0, mut1}, 2'b11);
    check(out0, 32'h0);
    check(out1, 32'h0);
    rd_reg(`SRTC_ADDR_STATUS, 8'h0c);
    wr_reg(`SRTC_ADDR_TXMUTE, 8'h10);
    repeat (3) @(negedge clk);
    check(mut1, 1'b0);
    check(out1, in1);
    @(posedge clk);
    pin0 <= 1'b1;
    repeat (8) @(negedge clk);
    check(mut0, 1'b0);
    check(out0, in0);
    $display("test pin mute done");
    give_verdict;
  end

  // watchdog: the tests need well under 1500 cycles
  initial begin
    #(40 * 5000);
    errors++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
